// ==== hw/ddrmz_pkg.sv ====
package ddrmz_pkg;
	// Command clock equals the DRAM clock, one command slot per cycle
	localparam int CLK_MHZ = 200;
	localparam int TRP_NS = 14;
	localparam int TRP_CYC = (TRP_NS * CLK_MHZ + 999) / 1000;
	localparam int TMRD_CK = 4;
	localparam int TMOD_CK = 12;
	localparam int TMRS_CYC = (TMOD_CK > TMRD_CK) ? TMOD_CK : TMRD_CK;
	localparam int TMPRR_CK = 1;
	localparam int TZQINIT_CK = 512;
	localparam int TZQCS_CK = 64;
	localparam int CL_CK = 5;
	localparam int AL_CK = 0;
	localparam int RL_CYC = AL_CK + CL_CK;

	// Software register offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_MRS = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_CAPT = 8'h0C;

	// CMD fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BC4_BIT = 4;
	localparam int CMD_HI_BIT = 5;
	localparam int CMD_RANK_BIT = 6;
	localparam int CMD_CNT_LSB = 8;
	// MRS fields
	localparam int MRS_A_LSB = 0;
	localparam int MRS_BA_LSB = 16;

	localparam logic [2:0] OP_ZQCL = 3'h1;
	localparam logic [2:0] OP_ZQCS = 3'h2;
	localparam logic [2:0] OP_MPR = 3'h3;
	localparam logic [2:0] OP_MRS = 3'h4;

	// {ras_n, cas_n, we_n}
	localparam logic [2:0] RCW_NOP = 3'h7;
	localparam logic [2:0] RCW_MRS = 3'h0;
	localparam logic [2:0] RCW_PRE = 3'h2;
	localparam logic [2:0] RCW_RD = 3'h5;
	localparam logic [2:0] RCW_WR = 3'h4;
	localparam logic [2:0] RCW_ZQ = 3'h6;

	localparam logic [2:0] MR3_BA = 3'h3;
	localparam logic [13:0] MR3_MPR_ON = 14'h0004;
	localparam logic [13:0] MR3_MPR_OFF = 14'h0000;
	localparam int A_AP_BIT = 10;
	localparam int A_BL_BIT = 12;
	localparam int A_NIB_BIT = 2;
	localparam logic [7:0] PAT_BL8 = 8'hAA;

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_PREA = 9'h002,
		S_MRS = 9'h004,
		S_MR3ON = 9'h008,
		S_READ = 9'h010,
		S_RDLAT = 9'h020,
		S_CAPT = 9'h040,
		S_MR3OFF = 9'h080,
		S_ZQ = 9'h100
	} ddrmz_st_t;
endpackage

// ==== hw/ddrmz_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] Device returns only the alternating 0,1 pattern; capture is checked against it.
// [RL2] BL8 read with column 000 returns positions 0..7 in order.
// [RL3] BC4 column 000 gives positions 0..3, column 100 gives 4..7.
// [RL4] MR3 readout select bits are always written as 00.
// [RL5] Burst position 0 lands in capture bit 0, position 7 in bit 7.
// [RL6] BL8 calibration reads drive zero on column bits 2..0.
// [RL7] BC4 reads drive zero on A1..A0; A2 picks lower or upper nibble.
// [RL8] Precharge all, wait row precharge, set MR3 bit 2, wait both delays.
// [RL9] No write command is ever issued.
// [RL10] Reads set A12 high for BL8, low for BC4; other address bits zero except A2 on upper-nibble BC4.
// [RL11] Data is sampled read latency cycles after each read command.
// [RL12] Reads repeat as asked, then after post-readout delay MR3 bit 2 cleared.
// [RL13] After leaving readout mode, both mode delays elapse before going idle.
// [RL14] Bank address selects the mode register; 011 targets MR3.
// [RL15] Mode writes follow precharge all and row precharge time.
// [RL16] After a mode write nothing is issued until both delays pass.
// [RL17] Calibration commands follow precharge all and row precharge time.
// [RL18] During impedance calibration the channel stays deselected.
// [RL19] Long and short impedance calibration commands are offered.
// [RL20] Long calibration is issued on request, e.g. after self refresh exit.
// [RL21] Operations run one at a time, so ranks never calibrate together.
// [RL22] Clock enable high, termination off, our data drivers released.
// [RL23] Device shuts its calibration path itself; nothing to drive here.
// [RL24] While readout mode is on only reads and the exit mode write occur.
module ddrmz_ctrl (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Software port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// DRAM command pins
	output logic cke_o,
	output logic [1:0] cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [2:0] ba_o,
	output logic [13:0] a_o,
	output logic odt_o,
	// DRAM data, lane 0 of each edge
	output logic dq_oe_n_o,
	input wire logic [7:0] dq_rise_i,
	input wire logic [7:0] dq_fall_i
);

	typedef struct packed {
		ddrmz_pkg::ddrmz_st_t st;
		ddrmz_pkg::ddrmz_st_t ret;
		logic [9:0] cnt;
		logic [2:0] op;
		logic rank;
		logic bc4;
		logic hi;
		logic [7:0] nrd;
		logic [1:0] beat;
		logic [2:0] mrs_ba;
		logic [13:0] mrs_a;
		logic [7:0] capt;
		logic pass;
		logic err;
		logic done;
		logic mpr;
		logic [31:0] rdata;
		logic cke;
		logic [1:0] cs_n;
		logic [2:0] rcw;
		logic [2:0] ba;
		logic [13:0] a;
		logic odt;
		logic dq_oe_n;
	} ddrmz_state_t;

	localparam ddrmz_state_t ST_RST = '{
		st: ddrmz_pkg::S_IDLE,
		ret: ddrmz_pkg::S_IDLE,
		cke: 1'b1,
		cs_n: 2'h3,
		rcw: ddrmz_pkg::RCW_NOP,
		dq_oe_n: 1'b1,
		default: '0
	};

	ddrmz_state_t s_ff;
	ddrmz_state_t nxt_s;
	logic [7:0] mask;

	always_comb begin
		nxt_s = s_ff;
		mask = 8'hFF;
		// Deselect unless a command is issued this cycle
		nxt_s.cs_n = 2'h3;
		nxt_s.rcw = ddrmz_pkg::RCW_NOP;
		nxt_s.ba = 3'h0;
		nxt_s.a = 14'h0000;
		nxt_s.cke = 1'b1; // [RL22]
		nxt_s.odt = 1'b0; // [RL22]
		nxt_s.dq_oe_n = 1'b1; // [RL9] [RL22]
		nxt_s.rdata = 32'h0000_0000;

		if (rd_i) begin
			case (addr_i)
				ddrmz_pkg::REG_MRS: nxt_s.rdata = {13'h0, s_ff.mrs_ba, 2'h0, s_ff.mrs_a};
				ddrmz_pkg::REG_STAT: nxt_s.rdata = {27'h0, s_ff.mpr, s_ff.done, s_ff.pass,
					s_ff.err, s_ff.st != ddrmz_pkg::S_IDLE};
				ddrmz_pkg::REG_CAPT: nxt_s.rdata = {24'h000000, s_ff.capt};
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end

		if (wr_i) begin
			case (addr_i)
				ddrmz_pkg::REG_MRS: begin
					nxt_s.mrs_a = wdata_i[ddrmz_pkg::MRS_A_LSB +: 14];
					nxt_s.mrs_ba = wdata_i[ddrmz_pkg::MRS_BA_LSB +: 3];
				end
				ddrmz_pkg::REG_STAT: begin
					nxt_s.err = 1'b0;
					nxt_s.done = 1'b0;
				end
				default: ;
			endcase
		end

		// Busy or unknown orders are refused, never queued
		if (wr_i && addr_i == ddrmz_pkg::REG_CMD) begin
			if (s_ff.st == ddrmz_pkg::S_IDLE && wdata_i[ddrmz_pkg::CMD_OP_LSB +: 3] >= ddrmz_pkg::OP_ZQCL
				&& wdata_i[ddrmz_pkg::CMD_OP_LSB +: 3] <= ddrmz_pkg::OP_MRS) begin
				nxt_s.op = wdata_i[ddrmz_pkg::CMD_OP_LSB +: 3];
				nxt_s.bc4 = wdata_i[ddrmz_pkg::CMD_BC4_BIT];
				nxt_s.hi = wdata_i[ddrmz_pkg::CMD_BC4_BIT] & wdata_i[ddrmz_pkg::CMD_HI_BIT];
				nxt_s.rank = wdata_i[ddrmz_pkg::CMD_RANK_BIT];
				nxt_s.nrd = wdata_i[ddrmz_pkg::CMD_CNT_LSB +: 8];
				nxt_s.done = 1'b0;
				nxt_s.st = ddrmz_pkg::S_PREA; // [RL21]
			end else begin
				nxt_s.err = 1'b1;
			end
		end

		case (s_ff.st)
			ddrmz_pkg::S_IDLE: begin
				nxt_s.cnt = 10'h000;
			end
			ddrmz_pkg::S_PREA: begin
				// Every order starts from all banks closed
				nxt_s.cs_n[s_ff.rank] = 1'b0; // [RL15] [RL17]
				nxt_s.rcw = ddrmz_pkg::RCW_PRE;
				nxt_s.a[ddrmz_pkg::A_AP_BIT] = 1'b1;
				nxt_s.cnt = 10'(ddrmz_pkg::TRP_CYC - 1); // [RL8]
				if (s_ff.op == ddrmz_pkg::OP_MPR) begin
					nxt_s.ret = ddrmz_pkg::S_MR3ON;
				end else if (s_ff.op == ddrmz_pkg::OP_MRS) begin
					nxt_s.ret = ddrmz_pkg::S_MRS;
				end else begin
					nxt_s.ret = ddrmz_pkg::S_ZQ;
				end
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			ddrmz_pkg::S_MRS: begin
				nxt_s.cs_n[s_ff.rank] = 1'b0;
				nxt_s.rcw = ddrmz_pkg::RCW_MRS;
				nxt_s.ba = s_ff.mrs_ba; // [RL14]
				nxt_s.a = s_ff.mrs_a;
				// A plain mode write may not open the readout or pick a reserved one
				if (s_ff.mrs_ba == ddrmz_pkg::MR3_BA) begin
					nxt_s.a = ddrmz_pkg::MR3_MPR_OFF; // [RL4] [RL24]
				end
				nxt_s.cnt = 10'(ddrmz_pkg::TMRS_CYC - 1); // [RL16]
				nxt_s.ret = ddrmz_pkg::S_IDLE;
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			ddrmz_pkg::S_MR3ON: begin
				nxt_s.cs_n[s_ff.rank] = 1'b0;
				nxt_s.rcw = ddrmz_pkg::RCW_MRS;
				nxt_s.ba = ddrmz_pkg::MR3_BA; // [RL14]
				nxt_s.a = ddrmz_pkg::MR3_MPR_ON; // [RL4] [RL8]
				nxt_s.mpr = 1'b1;
				nxt_s.capt = 8'h00;
				nxt_s.pass = 1'b1;
				nxt_s.cnt = 10'(ddrmz_pkg::TMRS_CYC - 1); // [RL8] [RL16]
				nxt_s.ret = ddrmz_pkg::S_READ;
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			ddrmz_pkg::S_READ: begin
				nxt_s.cs_n[s_ff.rank] = 1'b0;
				nxt_s.rcw = ddrmz_pkg::RCW_RD; // [RL24]
				nxt_s.a[ddrmz_pkg::A_BL_BIT] = ~s_ff.bc4; // [RL10]
				nxt_s.a[ddrmz_pkg::A_NIB_BIT] = s_ff.hi; // [RL6] [RL7] [RL3]
				nxt_s.cnt = 10'(ddrmz_pkg::RL_CYC - 1); // [RL11]
				nxt_s.ret = ddrmz_pkg::S_CAPT;
				nxt_s.beat = {s_ff.hi, 1'b0};
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			ddrmz_pkg::S_RDLAT: begin
				// Shared countdown for every wait; ret names where to go next
				if (s_ff.cnt == 10'h000) begin
					nxt_s.st = s_ff.ret;
					if (s_ff.ret == ddrmz_pkg::S_IDLE) begin
						nxt_s.done = 1'b1;
					end
				end else begin
					nxt_s.cnt = s_ff.cnt - 10'h001;
				end
			end
			ddrmz_pkg::S_CAPT: begin
				// Prime DQ only; rise carries even positions, fall odd ones
				nxt_s.capt[{s_ff.beat, 1'b0}] = dq_rise_i[0]; // [RL5] [RL2]
				nxt_s.capt[{s_ff.beat, 1'b1}] = dq_fall_i[0]; // [RL5]
				nxt_s.beat = s_ff.beat + 2'h1;
				if (s_ff.bc4) begin
					mask = s_ff.hi ? 8'hF0 : 8'h0F;
				end
				if ((s_ff.bc4 && s_ff.beat[0]) || s_ff.beat == 2'h3) begin
					if ((nxt_s.capt & mask) != (ddrmz_pkg::PAT_BL8 & mask)) begin
						nxt_s.pass = 1'b0; // [RL1]
					end
					if (s_ff.nrd > 8'h01) begin
						nxt_s.nrd = s_ff.nrd - 8'h01; // [RL12]
						nxt_s.st = ddrmz_pkg::S_READ;
					end else begin
						nxt_s.cnt = 10'(ddrmz_pkg::TMPRR_CK - 1); // [RL12]
						nxt_s.ret = ddrmz_pkg::S_MR3OFF;
						nxt_s.st = ddrmz_pkg::S_RDLAT;
					end
				end
			end
			ddrmz_pkg::S_MR3OFF: begin
				nxt_s.cs_n[s_ff.rank] = 1'b0;
				nxt_s.rcw = ddrmz_pkg::RCW_MRS;
				nxt_s.ba = ddrmz_pkg::MR3_BA;
				nxt_s.a = ddrmz_pkg::MR3_MPR_OFF; // [RL12]
				nxt_s.mpr = 1'b0;
				nxt_s.cnt = 10'(ddrmz_pkg::TMRS_CYC - 1); // [RL13]
				nxt_s.ret = ddrmz_pkg::S_IDLE;
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			ddrmz_pkg::S_ZQ: begin
				nxt_s.cs_n[s_ff.rank] = 1'b0;
				nxt_s.rcw = ddrmz_pkg::RCW_ZQ; // [RL19]
				nxt_s.a[ddrmz_pkg::A_AP_BIT] = (s_ff.op == ddrmz_pkg::OP_ZQCL); // [RL20]
				// Long form waits the init figure, the safe choice after self refresh
				if (s_ff.op == ddrmz_pkg::OP_ZQCL) begin
					nxt_s.cnt = 10'(ddrmz_pkg::TZQINIT_CK - 1); // [RL18]
				end else begin
					nxt_s.cnt = 10'(ddrmz_pkg::TZQCS_CK - 1); // [RL18]
				end
				nxt_s.ret = ddrmz_pkg::S_IDLE;
				nxt_s.st = ddrmz_pkg::S_RDLAT;
			end
			default: begin
				nxt_s.st = ddrmz_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_ff <= ST_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rdata_o = s_ff.rdata;
	assign cke_o = s_ff.cke;
	assign cs_n_o = s_ff.cs_n;
	assign ras_n_o = s_ff.rcw[2];
	assign cas_n_o = s_ff.rcw[1];
	assign we_n_o = s_ff.rcw[0];
	assign ba_o = s_ff.ba;
	assign a_o = s_ff.a;
	assign odt_o = s_ff.odt;
	assign dq_oe_n_o = s_ff.dq_oe_n;

	// Command decode for checking only
	logic sel;
	logic [2:0] rcw_q;
	assign sel = (cs_n_o != 2'h3);
	assign rcw_q = {ras_n_o, cas_n_o, we_n_o};

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_no_write;
		!(sel && rcw_q == ddrmz_pkg::RCW_WR);
	endproperty
	a_no_write: assert property (p_no_write) else $error("write command issued"); // [RL9]

	property p_mr3_fmt;
		sel && rcw_q == ddrmz_pkg::RCW_MRS && ba_o == ddrmz_pkg::MR3_BA |-> a_o[1:0] == 2'h0;
	endproperty
	a_mr3_fmt: assert property (p_mr3_fmt) else $error("reserved MR3 readout select"); // [RL4]

	property p_rd_bl8;
		sel && rcw_q == ddrmz_pkg::RCW_RD && a_o[ddrmz_pkg::A_BL_BIT] |-> a_o[2:0] == 3'h0;
	endproperty
	a_rd_bl8: assert property (p_rd_bl8) else $error("BL8 read column not zero"); // [RL6]

	property p_rd_bc4;
		sel && rcw_q == ddrmz_pkg::RCW_RD |-> a_o[1:0] == 2'h0 && a_o[11:3] == 9'h000;
	endproperty
	a_rd_bc4: assert property (p_rd_bc4) else $error("read address bits wrong"); // [RL7]

	property p_mpr_only_rd;
		s_ff.mpr && sel |-> rcw_q == ddrmz_pkg::RCW_RD || rcw_q == ddrmz_pkg::RCW_MRS;
	endproperty
	a_mpr_only_rd: assert property (p_mpr_only_rd) else $error("non-read during readout"); // [RL24]

	property p_zq_quiet;
		sel && rcw_q == ddrmz_pkg::RCW_ZQ |=> !sel [*8];
	endproperty
	a_zq_quiet: assert property (p_zq_quiet) else $error("command during calibration"); // [RL18]

	property p_zq_pins;
		sel && rcw_q == ddrmz_pkg::RCW_ZQ |-> cke_o && !odt_o ##1 cke_o && dq_oe_n_o;
	endproperty
	a_zq_pins: assert property (p_zq_pins) else $error("pins wrong during calibration"); // [RL22]

	property p_mrs_gap;
		sel && rcw_q == ddrmz_pkg::RCW_MRS |=> !sel [*8] ##1 !sel [*4];
	endproperty
	a_mrs_gap: assert property (p_mrs_gap) else $error("command inside mode delay"); // [RL16]

	property p_pre_gap;
		sel && rcw_q == ddrmz_pkg::RCW_PRE |=> !sel [*3];
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("command inside precharge time"); // [RL15]

	property p_rd_data;
		sel && rcw_q == ddrmz_pkg::RCW_RD |-> ##5 s_ff.st == ddrmz_pkg::S_CAPT;
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("capture not at read latency"); // [RL11]

endmodule

`default_nettype wire

// ==== bench/ddrmz_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddrmz_dev_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Command pins
	input wire logic cke_i,
	input wire logic [1:0] cs_n_i,
	input wire logic [2:0] rcw_i,
	input wire logic [2:0] ba_i,
	input wire logic [13:0] a_i,
	input wire logic odt_i,
	input wire logic dq_oe_n_i,
	input wire logic corrupt_i,
	// Data and observed state
	output logic [7:0] dq_rise_o,
	output logic [7:0] dq_fall_o,
	output logic [3:0][13:0] mr_o,
	output int n_rd_o,
	output int n_zq_o,
	output int n_viol_o,
	output logic zq_long_o,
	output logic [1:0] cs_last_o
);
	int since_pre;
	int since_mrs;
	int zq_left;
	int start;
	int win;
	logic [2:0] cmd;
	logic ok;
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mr_o = '0;
			n_rd_o = 0;
			n_zq_o = 0;
			n_viol_o = 0;
			zq_long_o = 1'b0;
			cs_last_o = 2'h3;
			since_pre = 0;
			since_mrs = 0;
			zq_left = 0;
			start = 0;
			win = 0;
			dq_rise_o <= 8'h01;
			dq_fall_o <= 8'h00;
		end else begin
			cmd = (cs_n_i != 2'h3) ? rcw_i : ddrmz_pkg::RCW_NOP;
			// Both ranks selected at once would let their calibrations overlap
			if (cs_n_i == 2'h0) n_viol_o++;
			if (cs_n_i != 2'h3) cs_last_o = cs_n_i;
			since_pre++;
			since_mrs++;
			if (!cke_i || odt_i) n_viol_o++;
			if (zq_left > 0) begin
				// Calibration path shuts itself off when this runs out
				zq_left--;
				if ((cmd != ddrmz_pkg::RCW_NOP && cmd != ddrmz_pkg::RCW_ZQ) || !dq_oe_n_i) n_viol_o++;
			end
			ok = cmd == ddrmz_pkg::RCW_NOP || cmd == ddrmz_pkg::RCW_RD || cmd == ddrmz_pkg::RCW_MRS;
			if (mr_o[3][2] && !ok) n_viol_o++;
			if (start > 0) start--;
			else if (win > 0) win--;
			case (cmd)
				ddrmz_pkg::RCW_PRE: if (a_i[ddrmz_pkg::A_AP_BIT]) since_pre = 0;
				ddrmz_pkg::RCW_MRS: begin
					if (since_pre < ddrmz_pkg::TRP_CYC || since_mrs < ddrmz_pkg::TMRS_CYC) n_viol_o++;
					if (ba_i == ddrmz_pkg::MR3_BA && a_i[2] && a_i[1:0] != 2'h0) n_viol_o++;
					if (!ba_i[2]) mr_o[ba_i[1:0]] = a_i;
					since_mrs = 0;
				end
				ddrmz_pkg::RCW_RD: begin
					if (!mr_o[3][2] || a_i[1:0] != 2'h0 || (a_i[ddrmz_pkg::A_BL_BIT] && a_i[2])) n_viol_o++;
					if (since_mrs < ddrmz_pkg::TMRS_CYC) n_viol_o++;
					n_rd_o++;
					// One cycle of slack each side of the burst window
					start = ddrmz_pkg::RL_CYC - 2;
					win = a_i[ddrmz_pkg::A_BL_BIT] ? 6 : 4;
				end
				ddrmz_pkg::RCW_WR: n_viol_o++;
				ddrmz_pkg::RCW_ZQ: begin
					if (since_pre < ddrmz_pkg::TRP_CYC) n_viol_o++;
					zq_long_o = a_i[ddrmz_pkg::A_AP_BIT];
					n_zq_o++;
					zq_left = zq_long_o ? ddrmz_pkg::TZQINIT_CK : ddrmz_pkg::TZQCS_CK;
				end
				default: ;
			endcase
			// Outside a burst the lane shows the inverse of the pattern
			ok = start == 0 && win > 0 && !corrupt_i;
			dq_rise_o <= ok ? 8'h00 : 8'h01;
			dq_fall_o <= ok ? 8'h01 : 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic corrupt = 1'b0;
	logic [31:0] rdata_o;
	logic cke_o, odt_o, dq_oe_n_o, ras_n_o, cas_n_o, we_n_o, zq_long;
	logic [1:0] cs_n_o;
	logic [2:0] ba_o;
	logic [13:0] a_o;
	logic [7:0] dq_rise_i, dq_fall_i;
	logic [3:0][13:0] mr;
	logic [1:0] cs_last;
	int n_rd, n_zq, n_viol, n_exp;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	logic rd_seen_ff = 1'b0;
	logic [63:0] q[$];
	logic [63:0] e;
	logic [7:0] xs [4] = '{8'hAA, 8'h0A, 8'hA0, 8'h55};
	logic [7:0] ms [4] = '{8'hFF, 8'h0F, 8'hF0, 8'hFF};

	initial forever #2.5 mclk_i = ~mclk_i;

	ddrmz_ctrl i_ddrmz_ctrl (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cke_o, .cs_n_o,
		.ras_n_o, .cas_n_o, .we_n_o, .ba_o, .a_o, .odt_o, .dq_oe_n_o, .dq_rise_i, .dq_fall_i);
	ddrmz_dev_model i_ddrmz_dev_model (.mclk_i, .rst_i, .cke_i(cke_o), .cs_n_i(cs_n_o),
		.rcw_i({ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o), .a_i(a_o), .odt_i(odt_o), .dq_oe_n_i(dq_oe_n_o),
		.corrupt_i(corrupt), .dq_rise_o(dq_rise_i), .dq_fall_o(dq_fall_i), .mr_o(mr), .n_rd_o(n_rd),
		.n_zq_o(n_zq), .n_viol_o(n_viol), .zq_long_o(zq_long), .cs_last_o(cs_last));

	task automatic wrap_up();
		if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		n_tests++;
		if ((got & m) !== (exp & m)) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		q.push_back({x, m});
		@(posedge mclk_i);
		rd_i <= 1'b0;
	endtask

	// Second write while busy must be refused
	task automatic run(input logic [31:0] cmd, input logic poke, input logic [31:0] st, input logic [31:0] m);
		wr(ddrmz_pkg::REG_STAT, 32'h0);
		wr(ddrmz_pkg::REG_CMD, cmd);
		if (poke) wr(ddrmz_pkg::REG_CMD, cmd);
		for (int i = 0; i < 400; i++) begin
			rd(ddrmz_pkg::REG_STAT, 32'h0, 32'h0);
			#1;
			if (rdata_o[3] === 1'b1) break;
		end
		rd(ddrmz_pkg::REG_STAT, st, m);
	endtask

	always @(posedge mclk_i) begin
		if (rd_seen_ff) begin
			e = q.pop_front();
			chk(rdata_o, e[63:32], e[31:0]);
		end
		rd_seen_ff <= rd_i;
	end

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			$display("CHECK FAILED %0t run did not finish", $time);
			wrap_up();
		end
	end

	initial begin
		logic [13:0] v;
		logic [7:0] c;
		logic r;
		void'($urandom(32'h2810));
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(ddrmz_pkg::REG_STAT, 32'h0, 32'hFFFFFFFF);
		rd(ddrmz_pkg::REG_CAPT, 32'h0, 32'hFFFFFFFF);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		// Reset in the middle of a calibration must abort it and park the pins
		wr(ddrmz_pkg::REG_CMD, 32'(ddrmz_pkg::OP_ZQCS));
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b1;
		@(posedge mclk_i);
		chk(32'({cs_n_o, cke_o, odt_o, dq_oe_n_o}), 32'h1D, 32'h1F);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		rd(ddrmz_pkg::REG_STAT, 32'h0, 32'hFFFFFFFF);
		for (int b = 0; b < 4; b++) begin
			v = 14'($urandom);
			wr(ddrmz_pkg::REG_MRS, {13'h0, 3'(b), 2'h0, v});
			rd(ddrmz_pkg::REG_MRS, {13'h0, 3'(b), 2'h0, v}, 32'h7FFFF);
			r = 1'($urandom);
			run({25'h0, r, 3'h0, ddrmz_pkg::OP_MRS}, 1'b0, 32'h8, 32'h1B);
			chk(32'(mr[b]), (b == 3) ? 32'h0 : 32'(v), 32'h3FFF);
			chk(32'(cs_last), r ? 32'h1 : 32'h2, 32'h3);
		end
		n_exp = 0;
		for (int k = 0; k < 4; k++) begin
			c = 8'($urandom_range(1, 4));
			r = 1'($urandom);
			n_exp += c;
			corrupt <= (k == 3);
			// Upper-nibble flag also set on BL8 orders, where it must be ignored
			run({16'h0, c, 1'b0, r, k != 1, k == 1 || k == 2, 1'b0, ddrmz_pkg::OP_MPR}, 1'b0,
				(k == 3) ? 32'h8 : 32'hC, 32'h1F);
			rd(ddrmz_pkg::REG_CAPT, 32'(xs[k]), 32'(ms[k]));
			chk(n_rd, n_exp, 32'hFFFFFFFF);
			chk(32'(mr[3]), 32'(ddrmz_pkg::MR3_MPR_OFF), 32'h3FFF);
			chk(32'(cs_last), r ? 32'h1 : 32'h2, 32'h3);
		end
		corrupt <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			run(32'((k == 1) ? ddrmz_pkg::OP_ZQCS : ddrmz_pkg::OP_ZQCL), 1'b1, 32'hA, 32'h1B);
			chk(32'(zq_long), 32'(k == 0), 32'h1);
			chk(n_zq, k + 1, 32'hFFFFFFFF);
		end
		for (int op = 0; op < 8; op++) begin
			if (op == 0 || op > 4) begin
				wr(ddrmz_pkg::REG_STAT, 32'h0);
				wr(ddrmz_pkg::REG_CMD, 32'(op));
				rd(ddrmz_pkg::REG_STAT, 32'h2, 32'h1B);
			end
		end
		chk(n_viol, 0, 32'hFFFFFFFF);
		repeat (3) @(posedge mclk_i);
		wrap_up();
	end
endmodule
`default_nettype wire
